// File: rtl/video_alpha_mixer_map.svh
// Summary of operation
// - every register steps on the master clock rising edge; delay setting follows its strobe
// - both 12-bit video inputs are captured on every rising clock edge
// - result is first times weight plus second times one minus weight
// - a captured weight above 1.0 is replaced by exactly 1.0
// - weight is unsigned fixed point, bit 11 worth one, each lower bit half
// - weight loads while its enable is high, otherwise the last one is kept
// - format select low means two's complement video, high means unsigned video
// - format and rounding selects travel with the samples captured beside them while the video, format and rounding groups hold one delay
// - summer result shifts left one bit, dropping its top bit, for extra precision
// - rounding adds one below the new LSB, then clears that bit and lower bits
// - the rounded result is held in a 13-bit output register driving the output
// - output enable is high while its drive control is low, low while it is high
// - a 15-bit delay setting holds five 3-bit groups, one per delayed signal
// - each group adds zero to seven extra pipeline stages, its binary value
// - group at setting bits 5 to 3 delays the second video input
// - setting shifts in serially, bit 0 first, sampled on strobe rising edges
// - skip high forces the delay setting to zero; low lets serial loads through
`ifndef VIDEO_ALPHA_MIXER_MAP_SVH
`define VIDEO_ALPHA_MIXER_MAP_SVH

`define DATA_W            12
`define WEIGHT_W          12
`define OUT_W             13
`define PROD_W            26
`define SUM_W             27
`define ADJ_MSB           22
`define ADJ_LSB           10
`define WEIGHT_ONE        12'h0800
`define DELAY_SETTING_W   15
`define DELAY_SETTING_RST 15'h0000
`define DELAY_GROUP_W     3
`define DELAY_GROUPS      5
`define DELAY_MAX_STAGES  7
`define SECOND_VIDEO_GROUP 3'h1
`define ROUND_TO_8        2'h0
`define ROUND_TO_10       2'h1
`define ROUND_TO_12       2'h2
`define ROUND_TO_13       2'h3
`define SIG_FIRST_VIDEO   0
`define SIG_SECOND_VIDEO  1
`define SIG_WEIGHT        2
`define SIG_FORMAT        3
`define SIG_ROUND         4
// group index per signal, signal 0 in the low three bits
`define GROUP_MAP_DEFAULT 15'h4688

`endif

// File: rtl/video_alpha_mixer_pkg.sv
`include "video_alpha_mixer_map.svh"

package video_alpha_mixer_pkg;

  typedef logic [`DELAY_GROUPS-1:0][`DELAY_GROUP_W-1:0] group_map_t;

  typedef struct packed {
    logic        [`DATA_W-1:0]   first_reg;
    logic        [`DATA_W-1:0]   second_reg;
    logic        [`WEIGHT_W-1:0] weight_reg;
    logic                        format_n_reg;
    logic        [1:0]           round_reg;
    logic signed [`PROD_W-1:0]   prod_first_reg;
    logic signed [`PROD_W-1:0]   prod_second_reg;
    logic        [1:0]           round_pipe_reg;
    logic        [`OUT_W-1:0]    mixed_reg;
  } mix_state_t;

  typedef struct packed {
    logic [`DELAY_SETTING_W-1:0] setting_reg;
    logic                        strobe_prev_reg;
  } loader_state_t;

endpackage

// File: rtl/delay_cfg_if.sv
`timescale 1ns/1ps
`include "video_alpha_mixer_map.svh"

interface delay_cfg_if;
  logic [`DELAY_SETTING_W-1:0] setting;

  modport provider (output setting);
  modport consumer (input setting);
endinterface

// File: rtl/variable_delay.sv
`timescale 1ns/1ps
`include "video_alpha_mixer_map.svh"

module variable_delay #(
  parameter int WIDTH      = `DATA_W,
  parameter int MAX_STAGES = `DELAY_MAX_STAGES
) (
  input  wire logic                     clk_in,
  input  wire logic                     reset_n_in,
  input  wire logic [WIDTH-1:0]         data_in,
  input  wire logic [`DELAY_GROUP_W-1:0] stages_in,
  output logic      [WIDTH-1:0]         data_out
);

  typedef struct packed {
    logic [MAX_STAGES-1:0][WIDTH-1:0] tap;
  } delay_state_t;

  delay_state_t state_reg;
  delay_state_t state_next;

  if (MAX_STAGES < 1 || MAX_STAGES >= (1 << `DELAY_GROUP_W) || WIDTH < 1) begin : g_bad_param
    $error("variable_delay: stage count or width out of range");
  end

  always_comb begin
    state_next = state_reg;
    state_next.tap[0] = data_in;
    for (int i = 1; i < MAX_STAGES; i++) begin
      state_next.tap[i] = state_reg.tap[i-1];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // zero stages passes straight through, n stages picks tap n-1
  always_comb begin
    if (stages_in == '0 || 32'(stages_in) > MAX_STAGES) begin
      data_out = data_in;
    end else begin
      data_out = state_reg.tap[stages_in - 1'b1];
    end
  end

endmodule

// File: rtl/delay_setting_loader.sv
`timescale 1ns/1ps
`include "video_alpha_mixer_map.svh"

module delay_setting_loader
  import video_alpha_mixer_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic serial_in,
  input  wire logic strobe_in,
  input  wire logic skip_in,
  delay_cfg_if.provider cfg
);

  loader_state_t state_reg;
  loader_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.strobe_prev_reg = strobe_in;
    if (skip_in) begin
      // skip wins over a load arriving in the same cycle
      state_next.setting_reg = `DELAY_SETTING_RST;
    end else if (strobe_in && !state_reg.strobe_prev_reg) begin
      // shift right so the first bit sent ends at bit 0
      state_next.setting_reg = {serial_in, state_reg.setting_reg[`DELAY_SETTING_W-1:1]};
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cfg.setting = state_reg.setting_reg;

endmodule

// File: rtl/video_alpha_mixer.sv
`timescale 1ns/1ps
`include "video_alpha_mixer_map.svh"

module video_alpha_mixer #(
  parameter video_alpha_mixer_pkg::group_map_t GROUP_MAP = `GROUP_MAP_DEFAULT
) (
  input  wire logic                   CLK_IN,
  input  wire logic                   RESET_N_IN,
  input  wire logic [`DATA_W-1:0]     FIRST_VIDEO_IN,
  input  wire logic [`DATA_W-1:0]     SECOND_VIDEO_IN,
  input  wire logic [`WEIGHT_W-1:0]   MIX_WEIGHT_IN,
  input  wire logic                   WEIGHT_LOAD_EN_IN,
  input  wire logic                   SIGNED_SELECT_N_IN,
  input  wire logic [1:0]             ROUND_SELECT_IN,
  input  wire logic                   OUT_DRIVE_N_IN,
  input  wire logic                   DELAY_SERIAL_IN,
  input  wire logic                   DELAY_LOAD_STROBE_IN,
  input  wire logic                   DELAY_SKIP_IN,
  output logic      [`OUT_W-1:0]      MIXED_OUT,
  output logic                        MIXED_OE_OUT
);

  import video_alpha_mixer_pkg::*;

  // the group for the second video input is fixed; the others may be
  // rearranged, but each group may serve only one signal
  for (genvar s = 0; s < `DELAY_GROUPS; s++) begin : g_map_check
    if (GROUP_MAP[s] >= `DELAY_GROUPS) begin : g_range
      $error("video_alpha_mixer: group index out of range");
    end
    for (genvar t = s + 1; t < `DELAY_GROUPS; t++) begin : g_unique
      if (GROUP_MAP[s] == GROUP_MAP[t]) begin : g_dup
        $error("video_alpha_mixer: two signals share one delay group");
      end
    end
  end
  if (GROUP_MAP[`SIG_SECOND_VIDEO] != `SECOND_VIDEO_GROUP) begin : g_second_check
    $error("video_alpha_mixer: second video must use group 1");
  end

  mix_state_t state_reg;
  mix_state_t state_next;

  delay_cfg_if cfg_bus ();

  delay_setting_loader u_loader (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .serial_in  (DELAY_SERIAL_IN),
    .strobe_in  (DELAY_LOAD_STROBE_IN),
    .skip_in    (DELAY_SKIP_IN),
    .cfg        (cfg_bus.provider)
  );

  // every signal, narrow ones zero padded, passes its own delay line
  logic [`DELAY_GROUPS-1:0][`DATA_W-1:0] chan_in;
  logic [`DELAY_GROUPS-1:0][`DATA_W-1:0] chan_out;

  always_comb begin
    chan_in                    = '0;
    chan_in[`SIG_FIRST_VIDEO]  = state_reg.first_reg;
    chan_in[`SIG_SECOND_VIDEO] = state_reg.second_reg;
    chan_in[`SIG_WEIGHT]       = state_reg.weight_reg;
    chan_in[`SIG_FORMAT][0]    = state_reg.format_n_reg;
    chan_in[`SIG_ROUND][1:0]   = state_reg.round_reg;
  end

  for (genvar s = 0; s < `DELAY_GROUPS; s++) begin : g_delay
    logic [`DELAY_GROUP_W-1:0] stages;

    // a group selects its 3-bit field of the setting
    assign stages = cfg_bus.setting[GROUP_MAP[s]*`DELAY_GROUP_W +: `DELAY_GROUP_W];

    variable_delay #(
      .WIDTH      (`DATA_W),
      .MAX_STAGES (`DELAY_MAX_STAGES)
    ) u_delay (
      .clk_in     (CLK_IN),
      .reset_n_in (RESET_N_IN),
      .data_in    (chan_in[s]),
      .stages_in  (stages),
      .data_out   (chan_out[s])
    );
  end

  logic [`DATA_W-1:0]   first_dly;
  logic [`DATA_W-1:0]   second_dly;
  logic [`WEIGHT_W-1:0] weight_dly;
  logic                 format_n_dly;
  logic [1:0]           round_dly;

  assign first_dly    = chan_out[`SIG_FIRST_VIDEO];
  assign second_dly   = chan_out[`SIG_SECOND_VIDEO];
  assign weight_dly   = chan_out[`SIG_WEIGHT];
  assign format_n_dly = chan_out[`SIG_FORMAT][0];
  assign round_dly    = chan_out[`SIG_ROUND][1:0];

  // widen a sample to 13 bits; both inputs follow the same format bit
  function automatic logic signed [`DATA_W:0] widen(input logic [`DATA_W-1:0] v,
                                                     input logic             unsigned_n);
    if (unsigned_n) begin
      widen = {1'b0, v};
    end else begin
      widen = {v[`DATA_W-1], v};
    end
  endfunction

  // values above 1.0 are pinned to exactly 1.0 so one minus weight stays >= 0
  function automatic logic [`WEIGHT_W-1:0] clamp_weight(input logic [`WEIGHT_W-1:0] w);
    if (w > `WEIGHT_ONE) begin
      clamp_weight = `WEIGHT_ONE;
    end else begin
      clamp_weight = w;
    end
  endfunction

  // half an output LSB is added, then the dropped bits are cleared;
  // the add wraps at full scale, the caller must leave headroom there
  function automatic logic [`OUT_W-1:0] round_result(input logic [`OUT_W-1:0] v,
                                                     input logic [1:0]        mode);
    case (mode)
      `ROUND_TO_8: begin
        round_result = (v + `OUT_W'h0010) & ~`OUT_W'h001F;
      end
      `ROUND_TO_10: begin
        round_result = (v + `OUT_W'h0004) & ~`OUT_W'h0007;
      end
      `ROUND_TO_12: begin
        round_result = (v + `OUT_W'h0001) & ~`OUT_W'h0001;
      end
      `ROUND_TO_13: begin
        round_result = v;
      end
      default: begin
        round_result = v;
      end
    endcase
  endfunction

  logic signed [`DATA_W:0]   first_wide;
  logic signed [`DATA_W:0]   second_wide;
  logic signed [`WEIGHT_W:0] weight_wide;
  logic signed [`WEIGHT_W:0] weight_rest;
  logic signed [`SUM_W-1:0]  sum;
  logic        [`OUT_W-1:0]  adjusted;

  always_comb begin
    first_wide  = widen(first_dly, format_n_dly);
    second_wide = widen(second_dly, format_n_dly);
    // bit 11 of the weight is worth one, so 1.0 is the value 0x800
    weight_wide = $signed({1'b0, weight_dly});
    weight_rest = $signed({1'b0, `WEIGHT_W'(`WEIGHT_ONE - weight_dly)});
    sum = `SUM_W'(state_reg.prod_first_reg) + `SUM_W'(state_reg.prod_second_reg);
    // top summer bit only carries sign extension since weight never exceeds one
    adjusted = sum[`ADJ_MSB:`ADJ_LSB];
  end

  always_comb begin
    state_next = state_reg;

    // input stage
    state_next.first_reg    = FIRST_VIDEO_IN;
    state_next.second_reg   = SECOND_VIDEO_IN;
    state_next.format_n_reg = SIGNED_SELECT_N_IN;
    state_next.round_reg    = ROUND_SELECT_IN;
    if (WEIGHT_LOAD_EN_IN) begin
      state_next.weight_reg = clamp_weight(MIX_WEIGHT_IN);
    end

    // multiply stage, after the programmable delays
    // widen before multiplying so the product is formed at full width
    state_next.prod_first_reg  = `PROD_W'(first_wide) * `PROD_W'(weight_wide);
    state_next.prod_second_reg = `PROD_W'(second_wide) * `PROD_W'(weight_rest);
    state_next.round_pipe_reg  = round_dly;

    // sum, adjust and round into the output register
    state_next.mixed_reg = round_result(adjusted, state_reg.round_pipe_reg);
  end

  // data flops are cleared too, but output is only meaningful after fill
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign MIXED_OUT    = state_reg.mixed_reg;
  // the drive control acts at once, without waiting for a clock edge
  assign MIXED_OE_OUT = ~OUT_DRIVE_N_IN;

endmodule

// File: tb/mixer_checker.sv
`timescale 1ns/1ps

module mixer_checker (
  input wire logic        CLK_IN,
  input wire logic        RESET_N_IN,
  input wire logic [11:0] FIRST_VIDEO_IN,
  input wire logic [11:0] SECOND_VIDEO_IN,
  input wire logic [11:0] MIX_WEIGHT_IN,
  input wire logic        WEIGHT_LOAD_EN_IN,
  input wire logic        SIGNED_SELECT_N_IN,
  input wire logic [1:0]  ROUND_SELECT_IN,
  input wire logic        OUT_DRIVE_N_IN,
  input wire logic        DELAY_SERIAL_IN,
  input wire logic        DELAY_LOAD_STROBE_IN,
  input wire logic        DELAY_SKIP_IN,
  input wire logic [12:0] MIXED_OUT,
  input wire logic        MIXED_OE_OUT
);
  logic [14:0] cfg_reg;
  logic        prev_reg;
  logic [3:0]  calm_reg;
  logic        load;
  logic        z;
  logic [12:0] half;
  assign load = DELAY_LOAD_STROBE_IN && !prev_reg && !DELAY_SKIP_IN;
  assign z    = calm_reg > 4'h7 && cfg_reg == 15'h0000;
  assign half = SIGNED_SELECT_N_IN ? {1'b0, FIRST_VIDEO_IN} + {1'b0, SECOND_VIDEO_IN}
                                   : {FIRST_VIDEO_IN[11], FIRST_VIDEO_IN} + {SECOND_VIDEO_IN[11], SECOND_VIDEO_IN};
  // mirror of the setting; the pipe depth is only known once it has been still for a while
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cfg_reg  <= 15'h0000;
      prev_reg <= 1'b0;
      calm_reg <= 4'h0;
    end else begin
      prev_reg <= DELAY_LOAD_STROBE_IN;
      cfg_reg  <= DELAY_SKIP_IN ? 15'h0000 : load ? {DELAY_SERIAL_IN, cfg_reg[14:1]} : cfg_reg;
      calm_reg <= (load || (DELAY_SKIP_IN && cfg_reg != 15'h0000)) ? 4'h0 : calm_reg + {3'h0, !(&calm_reg)};
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_oe;
    MIXED_OE_OUT == !OUT_DRIVE_N_IN;
  endproperty
  property p_rnd8;
    z && ROUND_SELECT_IN == 2'h0 |-> ##3 MIXED_OUT[4:0] == 5'h00;
  endproperty
  property p_rnd10;
    z && ROUND_SELECT_IN == 2'h1 |-> ##3 MIXED_OUT[2:0] == 3'h0;
  endproperty
  property p_rnd12;
    z && ROUND_SELECT_IN == 2'h2 |-> ##3 !MIXED_OUT[0];
  endproperty
  property p_one;
    z && WEIGHT_LOAD_EN_IN && MIX_WEIGHT_IN >= 12'h800 && ROUND_SELECT_IN == 2'h3
      |-> ##3 MIXED_OUT == {$past(FIRST_VIDEO_IN, 3), 1'b0};
  endproperty
  property p_zero;
    z && WEIGHT_LOAD_EN_IN && MIX_WEIGHT_IN == 12'h000 && ROUND_SELECT_IN == 2'h3
      |-> ##3 MIXED_OUT == {$past(SECOND_VIDEO_IN, 3), 1'b0};
  endproperty
  property p_hold;
    (z && WEIGHT_LOAD_EN_IN && MIX_WEIGHT_IN == 12'h000) ##1 (z && !WEIGHT_LOAD_EN_IN && ROUND_SELECT_IN == 2'h3)
      |-> ##3 MIXED_OUT == {$past(SECOND_VIDEO_IN, 3), 1'b0};
  endproperty
  property p_half;
    z && WEIGHT_LOAD_EN_IN && MIX_WEIGHT_IN == 12'h400 && ROUND_SELECT_IN == 2'h3 |-> ##3 MIXED_OUT == $past(half, 3);
  endproperty
  property p_sec4;
    calm_reg > 4'h7 && cfg_reg == 15'h0020 && WEIGHT_LOAD_EN_IN && MIX_WEIGHT_IN == 12'h000 && ROUND_SELECT_IN == 2'h3
      |-> ##3 MIXED_OUT == {$past(SECOND_VIDEO_IN, 7), 1'b0};
  endproperty
  a_oe: assert property (p_oe) else $error("output enable does not follow drive control");
  a_rnd8: assert property (p_rnd8) else $error("8 bit rounding leaves low bits");
  a_rnd10: assert property (p_rnd10) else $error("10 bit rounding leaves low bits");
  a_rnd12: assert property (p_rnd12) else $error("12 bit rounding leaves low bit");
  a_one: assert property (p_one) else $error("full weight does not pass first input");
  a_zero: assert property (p_zero) else $error("zero weight does not pass second input");
  a_hold: assert property (p_hold) else $error("held weight not kept");
  a_half: assert property (p_half) else $error("half weight sum wrong for format");
  a_sec4: assert property (p_sec4) else $error("second input delay of four wrong");
  c_half: cover property (z && WEIGHT_LOAD_EN_IN && MIX_WEIGHT_IN == 12'h400 && ROUND_SELECT_IN == 2'h3);
  c_sec4: cover property (cfg_reg == 15'h0020 && WEIGHT_LOAD_EN_IN && MIX_WEIGHT_IN == 12'h000);
  c_skip: cover property (DELAY_SKIP_IN && cfg_reg != 15'h0000);
endmodule

bind video_alpha_mixer mixer_checker chk (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .FIRST_VIDEO_IN(FIRST_VIDEO_IN), .SECOND_VIDEO_IN(SECOND_VIDEO_IN),
  .MIX_WEIGHT_IN(MIX_WEIGHT_IN), .WEIGHT_LOAD_EN_IN(WEIGHT_LOAD_EN_IN), .SIGNED_SELECT_N_IN(SIGNED_SELECT_N_IN),
  .ROUND_SELECT_IN(ROUND_SELECT_IN), .OUT_DRIVE_N_IN(OUT_DRIVE_N_IN), .DELAY_SERIAL_IN(DELAY_SERIAL_IN),
  .DELAY_LOAD_STROBE_IN(DELAY_LOAD_STROBE_IN), .DELAY_SKIP_IN(DELAY_SKIP_IN), .MIXED_OUT(MIXED_OUT),
  .MIXED_OE_OUT(MIXED_OE_OUT));

// File: tb/delay_ctl_model.sv
`timescale 1ns/1ps

module delay_ctl_model (
  input  wire logic clk_in,
  output logic      serial_out,
  output logic      strobe_out,
  output logic      skip_out
);
  initial begin
    serial_out = 1'b0;
    strobe_out = 1'b0;
    skip_out   = 1'b1;
  end
  // strobe idles low a whole cycle between bits
  task automatic load(input logic [14:0] value);
    for (int i = 0; i < 15; i++) begin
      @(negedge clk_in);
      serial_out <= value[i];
      strobe_out <= 1'b1;
      @(negedge clk_in);
      serial_out <= !value[i];
      strobe_out <= 1'b0;
    end
  endtask
  // callers only change skip while the video is idle
  task automatic set_skip(input logic value);
    @(negedge clk_in);
    skip_out <= value;
  endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [11:0] fv = 12'h000;
  logic [11:0] sv = 12'h000;
  logic [11:0] mw = 12'h000;
  logic        en = 1'b0;
  logic        sn = 1'b0;
  logic [1:0]  rs = 2'h0;
  logic        odn = 1'b0;
  logic        ser;
  logic        stb;
  logic        skip;
  logic [12:0] mixed;
  logic        oe;
  logic        drive_on = 1'b0;
  int          mismatches = 0;
  int          tests_run = 0;
  logic [11:0] w_tbl [4] = '{12'h000, 12'h400, 12'h800, 12'hfff};
  logic [14:0] m_set;
  logic        m_prev;
  int          m_w;
  int          hist [5][8];
  int          cur [5];
  int          tap [5];
  logic [12:0] exp_q [$];

  always #5 clk_in = !clk_in;

  delay_ctl_model ctl (.clk_in(clk_in), .serial_out(ser), .strobe_out(stb), .skip_out(skip));

  video_alpha_mixer dut (
    .CLK_IN(clk_in), .RESET_N_IN(reset_n_in), .FIRST_VIDEO_IN(fv), .SECOND_VIDEO_IN(sv), .MIX_WEIGHT_IN(mw),
    .WEIGHT_LOAD_EN_IN(en), .SIGNED_SELECT_N_IN(sn), .ROUND_SELECT_IN(rs), .OUT_DRIVE_N_IN(odn),
    .DELAY_SERIAL_IN(ser), .DELAY_LOAD_STROBE_IN(stb), .DELAY_SKIP_IN(skip), .MIXED_OUT(mixed), .MIXED_OE_OUT(oe));

  // forked from the seeded thread so the stimulus follows the seed
  task automatic drive_loop;
    forever begin
      @(negedge clk_in);
      if (drive_on) begin
        fv  <= 12'($urandom);
        sv  <= 12'($urandom);
        mw  <= $urandom_range(0, 1) ? w_tbl[$urandom_range(0, 3)] : 12'($urandom);
        en  <= 1'($urandom);
        sn  <= 1'($urandom);
        rs  <= 2'($urandom);
        odn <= 1'($urandom);
      end
    end
  endtask

  function automatic logic [12:0] mix(int a, int b, int w, int un, int r);
    logic signed [31:0] p;
    logic [12:0]        m;
    int                 sh;
    if (un == 0) begin
      a = (a ^ 2048) - 2048;
      b = (b ^ 2048) - 2048;
    end
    p  = a * w + b * (2048 - w);
    m  = p[22:10];
    sh = (r == 0) ? 5 : (r == 1) ? 3 : (r == 2) ? 1 : 0;
    if (sh > 0) m = (m + (13'h0001 << (sh - 1))) & ~((13'h0001 << sh) - 13'h0001);
    return m;
  endfunction

  task automatic chk_mix(input logic [12:0] e);
    tests_run++;
    if (mixed !== e) begin
      mismatches++;
      $display("[ERR] %0t mixed result exp %h got %h", $time, e, mixed);
    end
  endtask

  task automatic chk_oe;
    tests_run++;
    if (oe !== !odn) begin
      mismatches++;
      $display("[ERR] %0t output enable wrong", $time);
    end
  endtask

  // behavioural pipe: every signal keeps eight captures, its group picks the tap
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      m_set = 15'h0000;
      m_prev = 1'b0;
      m_w = 0;
      hist = '{default: 0};
      exp_q.delete();
    end else begin
      if (skip) m_set = 15'h0000;
      else if (stb && !m_prev) m_set = {ser, m_set[14:1]};
      m_prev = stb;
      if (en) m_w = (mw > 12'h800) ? 2048 : int'(mw);
      cur = '{int'(fv), int'(sv), m_w, int'(sn), int'(rs)};
      for (int j = 0; j < 5; j++) begin
        for (int i = 7; i > 0; i--) hist[j][i] = hist[j][i - 1];
        hist[j][0] = cur[j];
        tap[j] = hist[j][m_set[3 * j +: 3]];
      end
      exp_q.push_back(mix(tap[0], tap[1], tap[2], tap[3], tap[4]));
      #1;
      chk_oe();
      if (exp_q.size() == 3) chk_mix(exp_q.pop_front());
    end
  end

  task automatic run(input int n, input string name);
    drive_on = 1'b1;
    repeat (n) @(posedge clk_in);
    drive_on = 1'b0;
    $display("test %s done", name);
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100_000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    void'($urandom(32'h296e_8ee7));
    fork
      drive_loop();
    join_none
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    reset_n_in = 1'b1;
    run(300, "zero delay mix");
    ctl.set_skip(1'b0);
    ctl.load(15'h0020);
    run(300, "second input four stages late");
    for (int k = 0; k < 3; k++) begin
      ctl.load(15'($urandom));
      run(150, "random delay groups");
    end
    ctl.set_skip(1'b1);
    ctl.load(15'h7fff);
    run(100, "skip clears delays");
    @(negedge clk_in);
    reset_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    reset_n_in = 1'b1;
    run(100, "after second reset");
    final_report();
  end
endmodule
